// [src/watchdog_and_software_reset.sv]
// Contract
// - 5AH then A5H requests software reset
// - Software reset works with watchdog stopped
// - Clean software reset sets bit 2 only
// - Wrong sequence resets, sets bits 2,1
// - Bits 7:5 select 16K to 2048K
// - Overflow flag sticky until software clears
// - Bit 0 read-only running, reset clears
// - 1EH then E1H starts watchdog
// - Feed pair restarts count, expiry resets
// - Key register write-only, reads zero
// - Fourteen-bit timer behind seven-bit prescaler
// - Timeout is two to code plus 14
// - Disabled by reset, halted in power-down
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "wdt_consts.svh"

module watchdog_and_software_reset
    import wdt_types_pkg::*;
#(
    parameter int TIMER_W = `TIMER_BITS,
    parameter int PRESC_W = `PRESC_BITS,
    parameter int RST_PULSE = `RST_PULSE_CYC
)
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    // CPU power state and reset configuration
    input wire logic i_idle,
    input wire logic i_power_down,
    input wire logic i_reset_polarity,
    // Reset outputs
    output logic o_sys_reset,
    output logic o_rst_pin,
    output logic o_rst_pin_oe_n,
    // Interrupt
    output logic o_irq
);
    localparam logic [7:0] PULSE_LAST = 8'(RST_PULSE - 1);

    seq_state_t seq_q;
    seq_state_t seq_d;
    logic [7:0] pulse_q;
    logic [7:0] pulse_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic pin_drive_q;
    logic pin_drive_d;
    logic sys_rst_q;
    logic sys_rst_d;
    logic ack_q;
    logic ack_d;
    logic [7:0] rdat_q;
    logic [7:0] rdat_d;
    logic [`IRQ_W-1:0] stat_q;
    logic [`IRQ_W-1:0] stat_d;
    logic [`IRQ_W-1:0] mask_q;
    logic [`IRQ_W-1:0] mask_d;
    logic irq_q;
    logic irq_d;

    logic req;
    logic wr;
    logic [9:0] idx;
    logic key_wr;
    logic ctrl_wr;
    logic feed_ok;
    logic swr_ok;
    logic bad_seq;
    logic expire;
    logic reset_go;
    logic running;
    logic count_en;
    logic tb_clear;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] i);
        return a == i;
    endfunction

    assign req = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr = req && i_wb_we && i_wb_sel[0];
    assign idx = i_wb_adr[11:2];
    assign key_wr = wr && hit(idx, `KEY_IDX);
    assign ctrl_wr = wr && hit(idx, `CTRL_IDX);
    assign running = ctrl_q[`RUN_FLAG_BIT];

    assign count_en = running && !i_power_down
        && !(i_idle && ctrl_q[`IDLE_HALT_BIT]);
    assign tb_clear = feed_ok || !running;

    wdt_timebase
    #(
        .TIMER_W(TIMER_W),
        .PRESC_W(PRESC_W)
    )
    u_timebase
    (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_clear(tb_clear),
        .i_count_en(count_en),
        .i_sel(ctrl_q[`PS_MSB:`PS_LSB]),
        .o_expire(expire)
    );

    // Key sequence tracker
    always_comb
    begin
        seq_d = seq_q;
        pulse_d = pulse_q;
        feed_ok = 1'b0;
        swr_ok = 1'b0;
        bad_seq = 1'b0;
        case (seq_q)
            ST_IDLE:
            begin
                if (key_wr)
                begin
                    if (i_wb_dat[7:0] == `KEY_FEED_1)
                        seq_d = ST_FEED_HALF;
                    else if (i_wb_dat[7:0] == `KEY_SWR_1)
                        seq_d = ST_SWR_HALF;
                    else
                        bad_seq = 1'b1;
                end
            end
            ST_FEED_HALF:
            begin
                if (key_wr)
                begin
                    if (i_wb_dat[7:0] == `KEY_FEED_2)
                    begin
                        feed_ok = 1'b1;
                        seq_d = ST_IDLE;
                    end
                    else
                        bad_seq = 1'b1;
                end
            end
            ST_SWR_HALF:
            begin
                if (key_wr)
                begin
                    if (i_wb_dat[7:0] == `KEY_SWR_2)
                        swr_ok = 1'b1;
                    else
                        bad_seq = 1'b1;
                end
            end
            ST_RESET:
            begin
                if (pulse_q == 8'h00)
                    seq_d = ST_IDLE;
                else
                    pulse_d = pulse_q - 8'h01;
            end
            default:
            begin
                seq_d = ST_IDLE;
            end
        endcase
        if (swr_ok || bad_seq || (expire && running))
        begin
            seq_d = ST_RESET;
            pulse_d = PULSE_LAST;
        end
    end

    assign reset_go = swr_ok || bad_seq || (expire && running);

    // Control and status register
    always_comb
    begin
        ctrl_d = ctrl_q;
        pin_drive_d = pin_drive_q;
        if (ctrl_wr)
        begin
            ctrl_d[`PS_MSB:`RSTO_DIS_BIT] =
                i_wb_dat[`PS_MSB:`RSTO_DIS_BIT];
            // software clears flags by writing zero
            ctrl_d[`SWR_FLAG_BIT] =
                ctrl_q[`SWR_FLAG_BIT] && i_wb_dat[`SWR_FLAG_BIT];
            ctrl_d[`OVF_FLAG_BIT] =
                ctrl_q[`OVF_FLAG_BIT] && i_wb_dat[`OVF_FLAG_BIT];
        end
        if (feed_ok)
            ctrl_d[`RUN_FLAG_BIT] = 1'b1;
        if (reset_go)
        begin
            ctrl_d[`PS_MSB:`RSTO_DIS_BIT] =
                5'(`CTRL_RESET >> `RSTO_DIS_BIT);
            ctrl_d[`RUN_FLAG_BIT] = 1'b0;
            ctrl_d[`SWR_FLAG_BIT] = ctrl_d[`SWR_FLAG_BIT] || swr_ok
                || bad_seq;
            ctrl_d[`OVF_FLAG_BIT] = ctrl_d[`OVF_FLAG_BIT] || bad_seq
                || expire;
            pin_drive_d = !ctrl_q[`RSTO_DIS_BIT] && !swr_ok;
        end
        else if (seq_d != ST_RESET)
            pin_drive_d = 1'b0;
    end

    // Bus answer and interrupt logic
    always_comb
    begin
        ack_d = req;
        rdat_d = 8'h00;
        stat_d = stat_q;
        mask_d = mask_q;
        if (req && !i_wb_we)
        begin
            if (hit(idx, `CTRL_IDX))
                rdat_d = ctrl_q;
            else if (hit(idx, `IRQ_STAT_IDX))
                rdat_d = 8'(stat_q);
            else if (hit(idx, `IRQ_MASK_IDX))
                rdat_d = 8'(mask_q);
            else
                rdat_d = 8'h00;
        end
        if (wr && hit(idx, `IRQ_STAT_IDX))
            stat_d = stat_q & ~i_wb_dat[`IRQ_W-1:0];
        if (wr && hit(idx, `IRQ_MASK_IDX))
            mask_d = i_wb_dat[`IRQ_W-1:0];
        // Set wins over clear
        if (expire && running)
            stat_d[`IRQ_TIMEOUT_BIT] = 1'b1;
        if (bad_seq)
            stat_d[`IRQ_BADSEQ_BIT] = 1'b1;
        if (swr_ok)
            stat_d[`IRQ_SOFTWARE_RESET_FLAG_BIT] = 1'b1;
        irq_d = |(stat_d & mask_d);
        sys_rst_d = seq_d == ST_RESET;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            seq_q <= ST_IDLE;
            pulse_q <= 8'h00;
            ctrl_q <= `CTRL_RESET;
            pin_drive_q <= 1'b0;
            sys_rst_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 8'h00;
            stat_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end
        else if (i_ce)
        begin
            seq_q <= seq_d;
            pulse_q <= pulse_d;
            ctrl_q <= ctrl_d;
            pin_drive_q <= pin_drive_d;
            sys_rst_q <= sys_rst_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    // Pin level follows polarity while driven
    logic pin_q;
    logic pin_oe_n_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pin_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end
        else if (i_ce)
        begin
            pin_q <= i_reset_polarity;
            pin_oe_n_q <= !pin_drive_d;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = {24'h000000, rdat_q};
    assign o_sys_reset = sys_rst_q;
    assign o_rst_pin = pin_q;
    assign o_rst_pin_oe_n = pin_oe_n_q;
    assign o_irq = irq_q;
endmodule

// [src/wdt_consts.svh]
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// Register indices; byte address is four times the index
`define KEY_IDX 10'h0A6
`define CTRL_IDX 10'h0A7
`define IRQ_STAT_IDX 10'h0B0
`define IRQ_MASK_IDX 10'h0B1

// Control register reset pattern and field positions
`define CTRL_RESET 8'h00
`define PS_MSB 7
`define PS_LSB 5
`define IDLE_HALT_BIT 4
`define RSTO_DIS_BIT 3
`define SWR_FLAG_BIT 2
`define OVF_FLAG_BIT 1
`define RUN_FLAG_BIT 0

// Key bytes
`define KEY_FEED_1 8'h1E
`define KEY_FEED_2 8'hE1
`define KEY_SWR_1 8'h5A
`define KEY_SWR_2 8'hA5

// Timer structure and reset pulse length
`define TIMER_BITS 14
`define PRESC_BITS 7
`define RST_PULSE_CYC 16

// Interrupt status layout
`define IRQ_W 3
`define IRQ_TIMEOUT_BIT 0
`define IRQ_BADSEQ_BIT 1
`define IRQ_SOFTWARE_RESET_FLAG_BIT 2

`endif

// [src/wdt_types_pkg.sv]
package wdt_types_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_FEED_HALF = 2'b01,
        ST_SWR_HALF = 2'b10,
        ST_RESET = 2'b11
    } seq_state_t;

endpackage

// [src/wdt_timebase.sv]
`timescale 1ns/100ps
`include "wdt_consts.svh"

module wdt_timebase
#(
    parameter int TIMER_W = `TIMER_BITS,
    parameter int PRESC_W = `PRESC_BITS
)
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Control
    input wire logic i_clear,
    input wire logic i_count_en,
    input wire logic [2:0] i_sel,
    // Terminal count pulse
    output logic o_expire
);
    localparam int CNT_W = TIMER_W + PRESC_W;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic expire_q;
    logic expire_d;
    logic terminal;

    // Ones in the low TIMER_W+sel bits
    function automatic logic [CNT_W-1:0] low_mask(input logic [2:0] sel);
        logic [CNT_W-1:0] m;
        m = '0;
        for (int i = 0; i < CNT_W; i++)
        begin
            if (i < TIMER_W + int'(sel))
                m[i] = 1'b1;
        end
        return m;
    endfunction

    assign terminal = &(cnt_q | ~low_mask(i_sel));

    always_comb
    begin
        cnt_d = cnt_q;
        expire_d = 1'b0;
        if (i_clear)
            cnt_d = '0;
        else if (i_count_en)
        begin
            if (terminal)
            begin
                cnt_d = '0;
                expire_d = 1'b1;
            end
            else
                cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_q <= '0;
            expire_q <= 1'b0;
        end
        else if (i_ce)
        begin
            cnt_q <= cnt_d;
            expire_q <= expire_d;
        end
    end

    assign o_expire = expire_q;
endmodule

// [tb/wdog_check_sva.sv]
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdog_check_sva
#(
    parameter int RST_PULSE = `RST_PULSE_CYC
)
(
    // Clock and bus
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [31:0] o_wb_dat,
    // Reset side
    input wire logic i_reset_polarity,
    input wire logic o_sys_reset,
    input wire logic o_rst_pin,
    input wire logic o_rst_pin_oe_n,
    input wire logic o_irq
);
    logic [7:0] run_q, run_d;
    logic req, key_wr;
    assign req = i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign key_wr = req && i_wb_we && i_wb_sel[0]
        && i_wb_adr[11:2] == `KEY_IDX;
    // Length of the current reset pulse
    always_comb run_d = o_sys_reset ? run_q + 8'h01 : 8'h00;
    always_ff @(posedge i_sys_clk or negedge i_nrst)
        if (!i_nrst)
            run_q <= 8'h00;
        else
            run_q <= run_d;
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    AST_ACK_NEXT:
        assert property (req |=> o_wb_ack) else $error("ack missing");
    AST_ACK_DROP:
        assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
    AST_DAT_HIGH:
        assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_KEY_READ:
        assert property (req && !i_wb_we && i_wb_adr[11:2] == `KEY_IDX
            |=> o_wb_dat == 32'h00000000) else $error("key read not zero");
    AST_BAD_KEY:
        assert property (key_wr && !o_sys_reset && !(i_wb_dat[7:0] inside
            {8'h1E, 8'hE1, 8'h5A, 8'hA5}) |=> o_sys_reset)
        else $error("bad key without reset");
    AST_PULSE_LEN:
        assert property ($fell(o_sys_reset) |-> run_q == RST_PULSE)
        else $error("reset pulse too short");
    AST_PULSE_MAX:
        assert property (o_sys_reset |-> run_q < RST_PULSE)
        else $error("reset pulse too long");
    AST_PIN_OE:
        assert property (!o_rst_pin_oe_n |-> o_sys_reset)
        else $error("pin driven outside reset");
    AST_PIN_LEVEL:
        assert property (!o_rst_pin_oe_n |-> o_rst_pin ==
            $past(i_reset_polarity)) else $error("pin level wrong");
    cover property ($rose(o_sys_reset));
    cover property (!o_rst_pin_oe_n);
    cover property ($rose(o_irq));
endmodule
bind watchdog_and_software_reset wdog_check_sva #(.RST_PULSE(RST_PULSE))
    u_check (.i_sys_clk, .i_nrst, .i_ce, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_wb_dat,
    .i_reset_polarity, .o_sys_reset, .o_rst_pin, .o_rst_pin_oe_n, .o_irq);

// [tb/tb.sv]
`timescale 1ns/100ps
`include "wdt_consts.svh"
module tb;
    localparam logic [11:0] KA = {`KEY_IDX, 2'h0};
    localparam logic [11:0] CA = {`CTRL_IDX, 2'h0};
    localparam logic [11:0] SA = {`IRQ_STAT_IDX, 2'h0};
    localparam logic [11:0] MA = {`IRQ_MASK_IDX, 2'h0};
    logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, idle = 0, pd = 0;
    logic reset_polarity = 1'h1, ce = 1'h1, drove;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, srst, pin, oe_n, irq;
    logic [7:0] k1[3] = '{8'h5A, 8'h1E, 8'h33};
    logic [7:0] k2[3] = '{8'hA5, 8'h77, 8'h00};
    logic [7:0] ec[3] = '{8'h04, 8'h06, 8'h06};
    logic [7:0] es[3] = '{8'h04, 8'h02, 8'h02};
    int err_total = 0, n_tests = 0, n;
    always #20 clk = ~clk;
    watchdog_and_software_reset #(.TIMER_W(2)) dut (.i_sys_clk(clk),
        .i_nrst(nrst), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_idle(idle), .i_power_down(pd),
        .i_reset_polarity(reset_polarity), .o_sys_reset(srst), .o_rst_pin(pin),
        .o_rst_pin_oe_n(oe_n), .o_irq(irq));
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, logic [7:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        // Ack and read data taken at the rising edge
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'h1);
        chk("ack", ack, 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, logic [7:0] e, string nm);
        bus(1'h0, a, 8'h00);
        chk(nm, q, {24'h000000, e});
    endtask
    // Wait for a reset pulse and its end, noting pin drive
    task automatic pulse(input logic exp_drive);
        drove = 1'h0;
        n = 0;
        while (srst !== 1'h1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        repeat (20)
        begin
            @(negedge clk);
            drove |= !oe_n;
            if (!oe_n)
                chk("pin_level", pin, reset_polarity);
        end
        chk("pin_drive", drove, exp_drive);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        rd(CA, 8'h00, "ctrl_reset");
        rd(KA, 8'h00, "key_read");
        rd(12'h100, 8'h00, "unmapped");
        bus(1'h1, CA, 8'hFF);
        rd(CA, 8'hF8, "ctrl_ro");
        bus(1'h1, MA, 8'h07);
        // Idle with halt bit clear keeps counting
        idle <= 1'h1;
        for (int ps = 3; ps < 8; ps++)
        begin
            // Bit 1 written as one keeps the overflow flag
            bus(1'h1, CA, {ps[2:0], 1'h0, ps == 3, 3'h2});
            bus(1'h1, KA, 8'h1E);
            bus(1'h1, KA, 8'hE1);
            rd(CA, {ps[2:0], 1'h0, ps == 3, 1'h0, ps != 3, 1'h1}, "run");
            if (ps == 7)
            begin
                repeat (400) @(posedge clk);
                bus(1'h1, KA, 8'h1E);
                bus(1'h1, KA, 8'hE1);
            end
            pulse(ps != 3);
            chk("period", n > (4 << ps) - 7 && n < (4 << ps) + 3, 1);
        end
        idle <= 1'h0;
        rd(CA, 8'h02, "ctrl_timeout");
        rd(SA, 8'h01, "stat_timeout");
        chk("irq_on", irq, 1'h1);
        bus(1'h1, CA, 8'h70);
        bus(1'h1, KA, 8'h1E);
        bus(1'h1, KA, 8'hE1);
        idle <= 1'h1;
        repeat (60) @(posedge clk);
        idle <= 1'h0;
        pd <= 1'h1;
        repeat (60) @(posedge clk);
        pd <= 1'h0;
        // Clock enable low freezes the count
        ce <= 1'h0;
        repeat (60) @(posedge clk);
        ce <= 1'h1;
        pulse(1'h1);
        chk("halted", n > 25 && n < 35, 1);
        for (int i = 0; i < 3; i++)
        begin
            reset_polarity <= !i[0];
            bus(1'h1, SA, 8'h07);
            bus(1'h1, CA, 8'h00);
            bus(1'h1, KA, k1[i]);
            if (i < 2)
                bus(1'h1, KA, k2[i]);
            pulse(i > 0);
            rd(CA, ec[i], "ctrl_key");
            rd(SA, es[i], "stat_key");
        end
        bus(1'h1, MA, 8'h00);
        rd(MA, 8'h00, "mask");
        chk("irq_masked", irq, 1'h0);
        bus(1'h1, MA, 8'h07);
        rd(MA, 8'h07, "mask_on");
        chk("irq_unmasked", irq, 1'h1);
        // Write without byte lane zero is ignored
        sel <= 4'h0;
        bus(1'h1, MA, 8'h00);
        sel <= 4'hF;
        rd(MA, 8'h07, "mask_sel");
        chk("irq_sel", irq, 1'h1);
        bus(1'h1, SA, 8'h07);
        rd(SA, 8'h00, "stat_clear");
        chk("irq_off", irq, 1'h0);
        give_verdict();
    end
endmodule
